// ---- verilog/ref_sel_pkg.sv ----
// constants, register map and state codes for the reference current selector
package ref_sel_pkg;
	// clock and tick timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

	// widths and table size
	localparam int TIME_W = 16;
	localparam int CUR_W = 16;
	localparam int ADC_W = 12;
	localparam int IDX_W = 4;
	localparam int NUM_ENTRIES = 16;
	localparam logic [IDX_W-1:0] LAST_IDX = 4'hf;

	// register byte offsets and table bank codes
	localparam logic [7:0] REG_CHARGE = 8'h00;
	localparam logic [7:0] REG_TIMEOUT = 8'h04;
	localparam logic [7:0] REG_LEVEL = 8'h08;
	localparam logic [7:0] REG_BLANK = 8'h0c;
	localparam logic [7:0] REG_SAMPLE = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_MEAS = 8'h18;
	localparam logic [7:0] REG_REF = 8'h1c;
	localparam logic [1:0] BANK_THR = 2'h1;
	localparam logic [1:0] BANK_CUR = 2'h2;

	// status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_TOUT = 2;
	localparam int ST_SERIAL = 3;
	localparam int ST_IDX_LSB = 8;

	// reset values
	localparam logic [TIME_W-1:0] RST_CHARGE = 16'h0064;
	localparam logic [TIME_W-1:0] RST_TIMEOUT = 16'h0bb8;
	localparam logic [ADC_W-1:0] RST_LEVEL = 12'h3e0;
	localparam logic [15:0] RST_BLANK = 16'h000a;
	localparam logic [15:0] RST_SAMPLE = 16'h000c;
	localparam logic [TIME_W-1:0] RST_THR = 16'hffff;
	localparam logic [CUR_W-1:0] RST_CUR = 16'h0000;

	// determination sequence states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CHARGE = 3'b001,
		S_DISCH = 3'b010,
		S_SCAN = 3'b011,
		S_DONE = 3'b100
	} state_e;
endpackage : ref_sel_pkg

// ---- verilog/reference_current_selector.sv ----
// reference current selection by rc discharge timing, plus current-sense blanking and sampling
//
// Contract
// - blank overcurrent input after each turn-on
// - trigger current sample at configured instant
// - determination only at startup or open recovery
// - charge switch closed, pin high, for charge time
// - after charge, run timer and sample repeatedly
// - latch timer when sample drops below level
// - timeout ends measurement, last entry chosen
// - first threshold above time gives the index
// - sixteen-entry current table drives regulation reference
// - pin serves serial link once a determination has finished, not after reset
module reference_current_selector
	import ref_sel_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// sequence triggers
	input wire logic startup_i,
	input wire logic open_recover_i,
	// adc on the shared pin
	output logic adc_start_o,
	input wire logic adc_done_i,
	input wire logic [ADC_W-1:0] adc_data_i,
	// shared_ref_serial_pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	output logic charge_switch_o,
	// serial function side
	input wire logic uart_tx_i,
	input wire logic uart_tx_en_i,
	output logic uart_rx_o,
	output logic serial_en_o,
	// current sense path
	input wire logic sw_on_i,
	input wire logic cs_over_i,
	output logic oc_o,
	output logic cs_sample_o,
	// selection result
	output logic [CUR_W-1:0] ref_current_o,
	output logic [IDX_W-1:0] sel_index_o,
	output logic busy_o,
	output logic done_o,
	output logic timeout_o
);
	typedef struct packed {
		state_e st;
		logic [4:0] tick_cnt;
		logic [TIME_W-1:0] cnt;
		logic [TIME_W-1:0] timer;
		logic [TIME_W-1:0] meas;
		logic adc_busy;
		logic adc_start;
		logic [IDX_W-1:0] idx;
		logic [IDX_W-1:0] sel;
		logic [CUR_W-1:0] ref_cur;
		logic serial_en;
		logic done;
		logic tout;
		logic [TIME_W-1:0] charge;
		logic [TIME_W-1:0] tmo;
		logic [ADC_W-1:0] level;
		logic [15:0] blank;
		logic [15:0] sample;
		logic [NUM_ENTRIES-1:0][TIME_W-1:0] thr;
		logic [NUM_ENTRIES-1:0][CUR_W-1:0] cur;
		logic [15:0] blank_cnt;
		logic [15:0] sample_cnt;
		logic sample_pulse;
		logic ack;
		logic [31:0] dat;
	} state_s;

	state_s q_ff;
	state_s nxt_q;
	logic tick;
	logic access;
	logic [IDX_W-1:0] ent;
	logic below;

	// byte-lane merge for 16-bit fields
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = wd[7:0];
		if (sel[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction : merge16

	// combinational helpers
	assign tick = (q_ff.tick_cnt == TICK_LAST);
	assign access = wb_cyc_i && wb_stb_i && !q_ff.ack;
	assign ent = wb_adr_i[5:2];
	assign below = q_ff.adc_busy && adc_done_i && (adc_data_i < q_ff.level);

	// next-state logic: sequence, bus, blanking
	always_comb
	begin
		nxt_q = q_ff;
		nxt_q.adc_start = 1'b0;
		nxt_q.ack = access;
		nxt_q.tick_cnt = tick ? 5'h00 : q_ff.tick_cnt + 5'h01;
		case (q_ff.st)
			S_IDLE, S_DONE:
			begin
				if (startup_i || open_recover_i)
				begin
					nxt_q.st = S_CHARGE;
					nxt_q.cnt = '0;
					nxt_q.tick_cnt = 5'h00;
					nxt_q.serial_en = 1'b0;
					nxt_q.done = 1'b0;
					nxt_q.tout = 1'b0;
				end
			end
			S_CHARGE:
			begin
				if (tick)
				begin
					nxt_q.cnt = q_ff.cnt + 16'h0001;
					if (q_ff.cnt + 16'h0001 >= q_ff.charge)
					begin
						nxt_q.st = S_DISCH;
						nxt_q.timer = '0;
						nxt_q.adc_busy = 1'b0;
					end
				end
			end
			S_DISCH:
			begin
				if (tick && q_ff.timer != 16'hffff)
					nxt_q.timer = q_ff.timer + 16'h0001;
				if (!q_ff.adc_busy)
				begin
					nxt_q.adc_start = 1'b1;
					nxt_q.adc_busy = 1'b1;
				end
				else if (adc_done_i)
					nxt_q.adc_busy = 1'b0;
				if (below)
				begin
					nxt_q.meas = q_ff.timer;
					nxt_q.idx = '0;
					nxt_q.st = S_SCAN;
				end
				else if (q_ff.timer >= q_ff.tmo)
				begin
					nxt_q.sel = LAST_IDX;
					nxt_q.tout = 1'b1;
					nxt_q.ref_cur = q_ff.cur[LAST_IDX];
					nxt_q.serial_en = 1'b1;
					nxt_q.done = 1'b1;
					nxt_q.st = S_DONE;
				end
			end
			S_SCAN:
			begin
				// ascending scan, one entry per cycle
				if (q_ff.thr[q_ff.idx] > q_ff.meas || q_ff.idx == LAST_IDX)
				begin
					nxt_q.sel = q_ff.idx;
					nxt_q.ref_cur = q_ff.cur[q_ff.idx];
					nxt_q.serial_en = 1'b1;
					nxt_q.done = 1'b1;
					nxt_q.st = S_DONE;
				end
				else
					nxt_q.idx = q_ff.idx + 4'h1;
			end
			default:
				nxt_q.st = S_IDLE;
		endcase

		// edge blanking and sample instant counters
		if (sw_on_i)
		begin
			nxt_q.blank_cnt = q_ff.blank;
			nxt_q.sample_cnt = q_ff.sample;
		end
		else
		begin
			if (q_ff.blank_cnt != 16'h0000)
				nxt_q.blank_cnt = q_ff.blank_cnt - 16'h0001;
			if (q_ff.sample_cnt != 16'h0000)
				nxt_q.sample_cnt = q_ff.sample_cnt - 16'h0001;
		end
		nxt_q.sample_pulse = (q_ff.sample_cnt == 16'h0001) && !sw_on_i;

		// register writes
		if (access && wb_we_i)
		begin
			case (wb_adr_i[7:6])
				BANK_THR:
					nxt_q.thr[ent] = merge16(q_ff.thr[ent], wb_dat_i, wb_sel_i);
				BANK_CUR:
					nxt_q.cur[ent] = merge16(q_ff.cur[ent], wb_dat_i, wb_sel_i);
				default:
				begin
					case (wb_adr_i)
						REG_CHARGE:
							nxt_q.charge = merge16(q_ff.charge, wb_dat_i, wb_sel_i);
						REG_TIMEOUT:
							nxt_q.tmo = merge16(q_ff.tmo, wb_dat_i, wb_sel_i);
						REG_LEVEL:
							nxt_q.level = ADC_W'(merge16(16'(q_ff.level), wb_dat_i, wb_sel_i));
						REG_BLANK:
							nxt_q.blank = merge16(q_ff.blank, wb_dat_i, wb_sel_i);
						REG_SAMPLE:
							nxt_q.sample = merge16(q_ff.sample, wb_dat_i, wb_sel_i);
						default:
							nxt_q.dat = q_ff.dat;
					endcase
				end
			endcase
		end

		// register reads, unmapped addresses read zero
		nxt_q.dat = '0;
		if (access && !wb_we_i)
		begin
			case (wb_adr_i[7:6])
				BANK_THR:
					nxt_q.dat = 32'(q_ff.thr[ent]);
				BANK_CUR:
					nxt_q.dat = 32'(q_ff.cur[ent]);
				default:
				begin
					case (wb_adr_i)
						REG_CHARGE:
							nxt_q.dat = 32'(q_ff.charge);
						REG_TIMEOUT:
							nxt_q.dat = 32'(q_ff.tmo);
						REG_LEVEL:
							nxt_q.dat = 32'(q_ff.level);
						REG_BLANK:
							nxt_q.dat = 32'(q_ff.blank);
						REG_SAMPLE:
							nxt_q.dat = 32'(q_ff.sample);
						REG_STATUS:
						begin
							nxt_q.dat[ST_BUSY] = (q_ff.st != S_IDLE) && (q_ff.st != S_DONE);
							nxt_q.dat[ST_DONE] = q_ff.done;
							nxt_q.dat[ST_TOUT] = q_ff.tout;
							nxt_q.dat[ST_SERIAL] = q_ff.serial_en;
							nxt_q.dat[ST_IDX_LSB +: IDX_W] = q_ff.sel;
						end
						REG_MEAS:
							nxt_q.dat = 32'(q_ff.meas);
						REG_REF:
							nxt_q.dat = 32'(q_ff.ref_cur);
						default:
							nxt_q.dat = '0;
					endcase
				end
			endcase
		end
	end

	// state register with synchronous reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q_ff <= '0;
			q_ff.st <= S_IDLE;
			q_ff.charge <= RST_CHARGE;
			q_ff.tmo <= RST_TIMEOUT;
			q_ff.level <= RST_LEVEL;
			q_ff.blank <= RST_BLANK;
			q_ff.sample <= RST_SAMPLE;
			q_ff.thr <= {NUM_ENTRIES{RST_THR}};
			q_ff.cur <= {NUM_ENTRIES{RST_CUR}};
		end
		else
			q_ff <= nxt_q;
	end

	// outputs
	assign wb_ack_o = q_ff.ack;
	assign wb_dat_o = q_ff.dat;
	assign adc_start_o = q_ff.adc_start;
	assign charge_switch_o = (q_ff.st == S_CHARGE);
	assign pin_oe_o = charge_switch_o || (q_ff.serial_en && uart_tx_en_i);
	assign pin_o = charge_switch_o ? 1'b1 : uart_tx_i;
	assign uart_rx_o = q_ff.serial_en ? pin_i : 1'b1;
	assign serial_en_o = q_ff.serial_en;
	assign oc_o = cs_over_i && !sw_on_i && (q_ff.blank_cnt == 16'h0000);
	assign cs_sample_o = q_ff.sample_pulse;
	assign ref_current_o = q_ff.ref_cur;
	assign sel_index_o = q_ff.sel;
	assign busy_o = (q_ff.st != S_IDLE) && (q_ff.st != S_DONE);
	assign done_o = q_ff.done;
	assign timeout_o = q_ff.tout;

	// checks
	chk_charge_pin_high: assert property (@(posedge clk_i) disable iff (rst_i)
		charge_switch_o |-> pin_oe_o && pin_o)
		else $error("pin not driven high while charging");
	chk_serial_muted: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_o |-> !serial_en_o && uart_rx_o)
		else $error("serial active during determination");
	chk_blank_window: assert property (@(posedge clk_i) disable iff (rst_i)
		sw_on_i && q_ff.blank > 16'h0001 |=> !oc_o ##1 !oc_o)
		else $error("overcurrent seen inside blanking");
	chk_sample_instant: assert property (@(posedge clk_i) disable iff (rst_i)
		sw_on_i ##1 (!sw_on_i && q_ff.sample_cnt == 16'h0002) ##1 !sw_on_i |=> cs_sample_o)
		else $error("sample pulse misplaced");
	chk_start_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(busy_o) |-> $past(startup_i) || $past(open_recover_i))
		else $error("determination started without trigger");
	chk_adc_repeat: assert property (@(posedge clk_i) disable iff (rst_i)
		q_ff.st == S_DISCH && !q_ff.adc_busy |=> adc_start_o)
		else $error("no adc sample issued while discharging");
	chk_time_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		q_ff.st == S_DISCH && below |=> q_ff.st == S_SCAN && q_ff.meas == $past(q_ff.timer))
		else $error("discharge time not latched");
	chk_timeout_last: assert property (@(posedge clk_i) disable iff (rst_i)
		q_ff.st == S_DISCH && !below && q_ff.timer >= q_ff.tmo
		|=> sel_index_o == LAST_IDX && timeout_o && done_o)
		else $error("timeout did not select last entry");
	chk_scan_first: assert property (@(posedge clk_i) disable iff (rst_i)
		q_ff.st == S_SCAN && q_ff.thr[q_ff.idx] > q_ff.meas |=> sel_index_o == $past(q_ff.idx))
		else $error("wrong threshold index chosen");
	chk_scan_last: assert property (@(posedge clk_i) disable iff (rst_i)
		q_ff.st == S_SCAN && q_ff.idx == LAST_IDX |=> sel_index_o == LAST_IDX && done_o)
		else $error("no fallback to last entry");
	chk_ref_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(done_o) |-> ref_current_o == q_ff.cur[sel_index_o])
		else $error("reference differs from table entry");
	chk_serial_back: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(done_o) |-> serial_en_o && !busy_o)
		else $error("pin not returned to serial link");
endmodule : reference_current_selector

// ---- bench/rc_network_model.sv ----
// resistor-capacitor network on the shared pin, answering the adc
module rc_network_model
	import ref_sel_pkg::*;
(
	// clock
	input wire logic clk_i,
	// from the selector
	input wire logic adc_start_i,
	input wire logic charge_switch_i,
	input wire logic pin_o_i,
	input wire logic pin_oe_i,
	// from the bench
	input wire logic line_i,
	input wire logic [31:0] disch_ticks_i,
	// to the selector; the adc outputs are given a known level from time zero
	output logic adc_done_o = 1'b0,
	output logic [ADC_W-1:0] adc_data_o = 12'h5a5,
	output logic pin_level_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int since = 0;
	logic [1:0] pend = 2'b00;
	// driven pin wins, otherwise the serial line level shows
	assign pin_level_o = pin_oe_i ? pin_o_i : line_i;
	// discharge time runs from switch opening; data changes every cycle between answers
	always @(posedge clk_i)
	begin
		since <= charge_switch_i ? 0 : since + 1;
		pend <= {pend[0], adc_start_i};
		adc_done_o <= 1'b0;
		adc_data_o <= ~adc_data_o;
		if (pend[1])
		begin
			adc_done_o <= 1'b1;
			adc_data_o <= (since / TICK_CYCLES < disch_ticks_i) ? 12'hfff : 12'h010;
		end
	end
endmodule : rc_network_model

// ---- bench/reference_current_selector_tb.sv ----
// self-checking bench for the reference current selector
module reference_current_selector_tb;
	import ref_sel_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, st = 0, orc = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic tx = 1, tx_en = 0, sw_on = 0, cs_over = 0, line = 1;
	logic adc_start, adc_done, pin_in, pin_out, pin_oe, chg, rx, ser, oc, smp, ack, busy, done, tout;
	logic [ADC_W-1:0] adc_data;
	logic [CUR_W-1:0] refc;
	logic [IDX_W-1:0] idx;
	int disch = 0, fail_count = 0, comparisons = 0, chg_cyc = 0, starts = 0, bad = 0;
	int thr[NUM_ENTRIES], cur[NUM_ENTRIES];
	always #20 clk_i = ~clk_i;
	reference_current_selector dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .startup_i(st), .open_recover_i(orc), .adc_start_o(adc_start),
		.adc_done_i(adc_done), .adc_data_i(adc_data), .pin_i(pin_in), .pin_o(pin_out),
		.pin_oe_o(pin_oe), .charge_switch_o(chg), .uart_tx_i(tx), .uart_tx_en_i(tx_en),
		.uart_rx_o(rx), .serial_en_o(ser), .sw_on_i(sw_on), .cs_over_i(cs_over), .oc_o(oc),
		.cs_sample_o(smp), .ref_current_o(refc), .sel_index_o(idx), .busy_o(busy),
		.done_o(done), .timeout_o(tout));
	rc_network_model rc (.clk_i(clk_i), .adc_start_i(adc_start), .charge_switch_i(chg),
		.pin_o_i(pin_out), .pin_oe_i(pin_oe), .line_i(line), .disch_ticks_i(disch),
		.adc_done_o(adc_done), .adc_data_o(adc_data), .pin_level_o(pin_in));
	// watch charging drive and pin ownership while the sequence runs
	always @(posedge clk_i)
	begin
		if (chg === 1'b1) chg_cyc++;
		if (adc_start === 1'b1) starts++;
		if (chg === 1'b1 && !(pin_oe === 1'b1 && pin_out === 1'b1)) bad++;
		if (busy === 1'b1 && (ser !== 1'b0 || rx !== 1'b1)) bad++;
	end
	// compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : check
	// one classic wishbone cycle, released after the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		// only the watchdog ends a wait for the answer
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rd = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask : wb
	// reference choice: first threshold above the time, else last entry
	function automatic int pick(input int t);
		for (int n = 0; n < NUM_ENTRIES; n++)
			if (thr[n] > t) return n;
		return 15;
	endfunction : pick
	// one determination run with the network discharging after a given time
	task automatic measure(input logic via_open, input int ticks);
		int e;
		e = ticks >= 200 ? 15 : pick(ticks);
		disch = ticks;
		chg_cyc = 0;
		starts = 0;
		@(posedge clk_i);
		st <= !via_open;
		orc <= via_open;
		@(posedge clk_i);
		st <= 0;
		orc <= 0;
		// busy shows one edge after the trigger is taken
		@(posedge clk_i);
		while (busy !== 1'b0)
			@(posedge clk_i);
		#5;
		check("index", e, idx);
		check("reference", cur[e], refc);
		check("timeout flag", ticks >= 200, tout);
		check("done", 1, done);
		check("charge cycles", 2 * TICK_CYCLES, chg_cyc);
		check("adc samples", 1, starts > 1);
		check("serial owner", 1, ser);
		$display("test measure %0d ticks done", ticks);
	endtask : measure
	// closing verdict
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// watchdog
	initial
	begin
		#2000000;
		fail_count++;
		give_verdict();
	end
	// main sequence
	initial
	begin
		void'($urandom(99384));
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		repeat (30) @(posedge clk_i);
		check("no start without trigger", 0, starts + busy);
		wb(1, REG_CHARGE, 32'h2);
		wb(1, REG_TIMEOUT, 32'd200);
		for (int n = 0; n < NUM_ENTRIES; n++)
		begin
			thr[n] = 10 * (n + 1);
			cur[n] = 16'h0100 + $urandom % 16'h0300;
			wb(1, 8'h40 + 8'(4 * n), thr[n]);
			wb(1, 8'h80 + 8'(4 * n), cur[n]);
		end
		for (int i = 0; i < 5; i++)
			measure(i[0], 10 * ($urandom % 15) + 5);
		measure(0, 175);
		measure(1, 1000);
		wb(0, REG_STATUS, 0);
		check("status", 32'h0f0e, rd);
		wb(1, REG_REF, 32'h1234);
		wb(0, REG_REF, 0);
		check("read only ref", cur[15], rd);
		wb(0, 8'h30, 0);
		check("unmapped read", 0, rd);
		check("pin ownership", 0, bad);
		// serial path after selection
		@(posedge clk_i);
		line <= 0;
		tx <= 0;
		tx_en <= 1;
		#45;
		check("rx follows pin", 0, rx);
		check("tx drives pin", 2'b10, {pin_oe, pin_out});
		$display("test serial done");
		// blanking and sample instant, in both orders
		for (int k = 0; k < 2; k++)
		begin
			wb(1, REG_BLANK, k ? 6 : 3);
			wb(1, REG_SAMPLE, k ? 2 : 5);
			@(posedge clk_i);
			sw_on <= 1;
			cs_over <= 1;
			for (int c = 0; c < 9; c++)
			begin
				#5;
				check("oc", c > (k ? 6 : 3), oc);
				// pulse stands one cycle after the counter reaches one
				check("sample", c == 1 + (k ? 2 : 5), smp);
				@(posedge clk_i);
				sw_on <= 0;
			end
			cs_over <= 0;
			$display("test blanking %0d done", k);
		end
		give_verdict();
	end
endmodule : reference_current_selector_tb
